// File: inc/rcs_consts.svh
/*
  Constants of the reader command sequencer: command codes, argument counts,
  address limits and sizes.
  Assumes it is included by bare name from the package or design files.
*/
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

`define RCS_CMD_IDLE      8'h00
`define RCS_CMD_LPCD      8'h01
`define RCS_CMD_LOADKEY   8'h02
`define RCS_CMD_AUTH      8'h03
`define RCS_CMD_ACKREQ    8'h04
`define RCS_CMD_RECEIVE   8'h05
`define RCS_CMD_TRANSMIT  8'h06
`define RCS_CMD_TRANSCV   8'h07
`define RCS_CMD_WRE2      8'h08
`define RCS_CMD_WRPAGE    8'h09
`define RCS_CMD_RDE2      8'h0a
`define RCS_CMD_LOADREG   8'h0c
`define RCS_CMD_LOADPROT  8'h0d
`define RCS_CMD_KEYFETCH  8'h0e
`define RCS_CMD_KEYSTORE  8'h0f
`define RCS_CMD_RANDOM    8'h1c
`define RCS_CMD_SOFTRST   8'h1f

`define RCS_AUTH_A        8'h60
`define RCS_AUTH_B        8'h61
`define RCS_KEY_BYTES     8'h06
`define RCS_PAGE_BYTES    8'h40
`define RCS_NV_LAST       13'h1fff
`define RCS_SECTOR_SEL    2'h2

`endif

// File: inc/rcs_pkg.sv
/*
  Types of the reader command sequencer.
  Assumes rcs_consts.svh sits on the include path.
*/
package rcs_pkg;
  typedef enum logic [3:0] {
    RCS_IDLE, RCS_ARGS, RCS_LPCD, RCS_KEYLOAD, RCS_AUTH, RCS_ACKREQ, RCS_RX, RCS_TX,
    RCS_NVWR, RCS_NVRD, RCS_REGLOAD, RCS_PROT, RCS_KEYNV, RCS_RANDOM, RCS_RESET
  } rcs_state_e;
  typedef logic [7:0] rcs_byte_t;
endpackage : rcs_pkg

// File: tb/rcs_far_model.sv
/*
  Far-side model of the command sequencer: the shared FIFO, the nonvolatile memory and the transmitter.
  Assumes the bench loads the FIFO with put_byte between clock edges and may set nv_wait for slow answers.
*/
`timescale 1ns/100ps
`default_nettype none
module rcs_far_model (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // FIFO side.
  input  wire logic        fifo_pop_i,
  input  wire logic        fifo_push_i,
  input  wire logic [7:0]  fifo_push_data_i,
  output logic             fifo_valid_o,
  output logic      [7:0]  fifo_data_o,
  output logic      [8:0]  fifo_count_o,
  output logic             fifo_full_o,
  // Memory and transmitter.
  input  wire logic        nv_rd_i,
  input  wire logic        nv_wr_i,
  input  wire logic [12:0] nv_addr_i,
  output logic             nv_ack_o,
  output logic      [7:0]  nv_rdata_o,
  output logic             tx_done_o
);
  logic [7:0] mem_ff [0:511];
  logic [8:0] rd_ff = 9'h000;
  logic [8:0] wr_ff = 9'h000;
  int         wait_ff;
  int         nv_wait = 0;

  // An empty FIFO shows the inverse of its last byte, so stale data never looks valid.
  assign fifo_count_o = wr_ff - rd_ff;
  assign fifo_valid_o = (fifo_count_o != 9'h000);
  assign fifo_data_o  = fifo_valid_o ? mem_ff[rd_ff] : ~mem_ff[rd_ff - 9'h001];
  assign fifo_full_o  = (fifo_count_o >= 9'h014);
  assign tx_done_o    = !fifo_valid_o;

  // Host load path, used between edges only.
  task put_byte(input logic [7:0] b);
    mem_ff[wr_ff] = b;
    wr_ff = wr_ff + 9'h001;
  endtask : put_byte

  // FIFO pops and pushes land on the rising edge.
  always @(posedge core_clk_i) begin
    if (fifo_pop_i && fifo_valid_o) rd_ff <= rd_ff + 9'h001;
    if (fifo_push_i) begin
      mem_ff[wr_ff] <= fifo_push_data_i;
      wr_ff         <= wr_ff + 9'h001;
    end
  end

  // Memory answers after nv_wait idle cycles; read data is a function of the address.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ff    <= 0;
      nv_ack_o   <= 1'b0;
      nv_rdata_o <= 8'h00;
    end else if ((nv_rd_i || nv_wr_i) && !nv_ack_o) begin
      if (wait_ff >= nv_wait) begin
        nv_ack_o   <= 1'b1;
        nv_rdata_o <= nv_addr_i[7:0] ^ 8'h3c;
        wait_ff    <= 0;
      end else begin
        wait_ff <= wait_ff + 1;
      end
    end else begin
      nv_ack_o   <= 1'b0;
      nv_rdata_o <= ~nv_rdata_o;
    end
  end
endmodule : rcs_far_model
`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench of the command sequencer, one task per scenario.
  Assumes rcs_far_model plays the FIFO, memory and transmitter; unit completions come from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rcs_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       reset_n_i  = 1'b0;
  logic       cmd_wr_i   = 1'b0;
  rcs_byte_t  cmd_code_i = 8'h00;
  logic       unit_done_i = 1'b0;
  rcs_byte_t  random_byte_i = 8'h00;
  logic [7:0] cmd_readback_o, fifo_data_i, fifo_push_data_o, key_data_o, nv_wdata_o, nv_rdata_i;
  logic [7:0] target_register_offset_o, reg_data_o, preset_rx_o, preset_tx_o;
  logic [8:0] fifo_count_i;
  logic [12:0] nv_addr_o;
  logic [2:0] key_idx_o;
  logic       busy_o, fifo_valid_i, fifo_full_i, fifo_pop_o, fifo_push_o, lpcd_start_o, auth_start_o;
  logic       ackreq_start_o, tx_en_o, rx_en_o, tx_done_i, key_wr_o, nv_rd_o, nv_wr_o, nv_ack_i;
  logic       reg_wr_o, preset_start_o, soft_reset_o, error_o;
  logic [7:0] pop_q[$], push_q[$], key_q[$];
  logic [20:0] nvw_q[$];
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;

  rcs_sequencer rcs_sequencer_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_wr_i(cmd_wr_i),
    .cmd_code_i(cmd_code_i), .cmd_readback_o(cmd_readback_o), .busy_o(busy_o), .fifo_valid_i(fifo_valid_i),
    .fifo_data_i(fifo_data_i), .fifo_count_i(fifo_count_i), .fifo_full_i(fifo_full_i), .fifo_pop_o(fifo_pop_o),
    .fifo_push_o(fifo_push_o), .fifo_push_data_o(fifo_push_data_o), .lpcd_start_o(lpcd_start_o),
    .auth_start_o(auth_start_o), .ackreq_start_o(ackreq_start_o), .tx_en_o(tx_en_o), .rx_en_o(rx_en_o),
    .unit_done_i(unit_done_i), .tx_done_i(tx_done_i), .key_wr_o(key_wr_o), .key_idx_o(key_idx_o),
    .key_data_o(key_data_o), .nv_rd_o(nv_rd_o), .nv_wr_o(nv_wr_o), .nv_addr_o(nv_addr_o),
    .nv_wdata_o(nv_wdata_o), .nv_ack_i(nv_ack_i), .nv_rdata_i(nv_rdata_i), .reg_wr_o(reg_wr_o),
    .target_register_offset_o(target_register_offset_o), .reg_data_o(reg_data_o),
    .preset_start_o(preset_start_o), .preset_rx_o(preset_rx_o), .preset_tx_o(preset_tx_o),
    .random_byte_i(random_byte_i), .soft_reset_o(soft_reset_o), .error_o(error_o));

  rcs_far_model rcs_far_model_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .fifo_pop_i(fifo_pop_o),
    .fifo_push_i(fifo_push_o), .fifo_push_data_i(fifo_push_data_o), .fifo_valid_o(fifo_valid_i),
    .fifo_data_o(fifo_data_i), .fifo_count_o(fifo_count_i), .fifo_full_o(fifo_full_i), .nv_rd_i(nv_rd_o),
    .nv_wr_i(nv_wr_o), .nv_addr_i(nv_addr_o), .nv_ack_o(nv_ack_i), .nv_rdata_o(nv_rdata_i),
    .tx_done_o(tx_done_i));

  // Clock at 250 MHz.
  always #2 core_clk_i = ~core_clk_i;

  // Traffic logs and the hang limit; the limit is far above the few hundred cycles the tests need.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    random_byte_i <= random_byte_i + 8'h07;
    if (fifo_pop_o && fifo_valid_i) pop_q.push_back(fifo_data_i);
    if (fifo_push_o) push_q.push_back(fifo_push_data_o);
    if (key_wr_o) key_q.push_back(key_data_o);
    if (nv_wr_o && nv_ack_i) nvw_q.push_back({nv_addr_o, nv_wdata_o});
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task summarize();
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task send_cmd(input logic [7:0] code);
    @(negedge core_clk_i);
    cmd_wr_i   = 1'b1;
    cmd_code_i = code;
    @(negedge core_clk_i);
    cmd_wr_i = 1'b0;
  endtask : send_cmd

  // Arguments go into the FIFO model between edges, before the command or, in t_keyload, partly after it.
  task load(input logic [7:0] b[$]);
    @(negedge core_clk_i);
    foreach (b[i]) rcs_far_model_i.put_byte(b[i]);
  endtask : load

  task pulse_done();
    @(negedge core_clk_i);
    unit_done_i = 1'b1;
    @(negedge core_clk_i);
    unit_done_i = 1'b0;
  endtask : pulse_done

  function logic sig(input int sel);
    case (sel)
      0: return lpcd_start_o;
      1: return auth_start_o;
      2: return rx_en_o;
      3: return preset_start_o;
      default: return soft_reset_o;
    endcase
  endfunction : sig

  task wait_sig(input string what, input int sel);
    int n;
    n = 0;
    while (sig(sel) !== 1'b1 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(what, 21'h1, {20'h0, sig(sel)});
  endtask : wait_sig

  task wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 300) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("busy", 21'h0, {20'h0, busy_o});
    @(negedge core_clk_i);
    chk("readback", 21'h0, {13'h0, cmd_readback_o});
  endtask : wait_idle

  // Card detection starts from its code and ends on the unit's completion.
  task t_lpcd();
    send_cmd(8'h01);
    chk("readback", 21'h01, {13'h0, cmd_readback_o});
    wait_sig("lpcd_start", 0);
    pulse_done();
    wait_idle();
  endtask : t_lpcd

  // Key load with half the key present must wait for the rest.
  task t_keyload();
    load('{8'h11, 8'h12, 8'h13});
    send_cmd(8'h02);
    repeat (10) @(negedge core_clk_i);
    chk("key writes early", 21'h0, key_q.size());
    load('{8'h14, 8'h15, 8'h16});
    wait_idle();
    chk("key writes", 21'h6, key_q.size());
    foreach (key_q[i]) chk("key byte", 21'h11 + i, {13'h0, key_q[i]});
  endtask : t_keyload

  // Receive leaves the FIFO alone, idle code cancels it, then transmit drains in order.
  task t_rx_abort_tx();
    load('{8'ha1, 8'hb2});
    send_cmd(8'h05);
    wait_sig("rx_en", 2);
    chk("fifo kept", 21'h2, {12'h0, fifo_count_i});
    send_cmd(8'h00);
    wait_idle();
    chk("rx_en off", 21'h0, {20'h0, rx_en_o});
    load('{8'hc3});
    pop_q.delete();
    send_cmd(8'h06);
    wait_idle();
    chk("tx pops", 21'h3, pop_q.size());
    if (pop_q.size() == 3) chk("tx order", 21'hc3b2a1, {pop_q[2], pop_q[1], pop_q[0]});
  endtask : t_rx_abort_tx

  // Transceive turns the receiver on by itself once the FIFO is sent.
  task t_transceive();
    load('{8'h5e, 8'h6f});
    send_cmd(8'h07);
    wait_sig("rx after tx", 2);
    chk("fifo sent", 21'h0, {12'h0, fifo_count_i});
    pulse_done();
    wait_idle();
  endtask : t_transceive

  // Memory byte write with a slow memory, then a read across the top address.
  task t_nv();
    rcs_far_model_i.nv_wait = 2;
    load('{8'h01, 8'h23, 8'h5a});
    send_cmd(8'h08);
    wait_idle();
    chk("nv writes", 21'h1, nvw_q.size());
    if (nvw_q.size() == 1) chk("nv write", {13'h0123, 8'h5a}, nvw_q[0]);
    rcs_far_model_i.nv_wait = 0;
    push_q.delete();
    load('{8'h1f, 8'hfe, 8'h03});
    send_cmd(8'h0a);
    wait_idle();
    chk("read count", 21'h3, push_q.size());
    if (push_q.size() == 3) chk("read wrap", 21'h3cc3c2, {push_q[2], push_q[1], push_q[0]});
    send_cmd(8'h06);
    wait_idle();
    chk("fifo drained", 21'h0, {12'h0, fifo_count_i});
  endtask : t_nv

  // Authentication with both codes, preset load, random fill and soft reset.
  task t_misc();
    for (int k = 0; k < 2; k++) begin
      load('{8'h60 + k, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04});
      send_cmd(8'h03);
      wait_sig("auth_start", 1);
      pulse_done();
      wait_idle();
    end
    load('{8'h02, 8'h05});
    send_cmd(8'h0d);
    wait_sig("preset_start", 3);
    repeat (4) @(negedge core_clk_i);
    chk("preset", 21'h0205, {5'h0, preset_rx_o, preset_tx_o});
    pulse_done();
    wait_idle();
    send_cmd(8'h1c);
    wait_idle();
    chk("fill level", 21'h14, {12'h0, fifo_count_i});
    send_cmd(8'h1f);
    wait_sig("soft reset", 4);
  endtask : t_misc

  initial begin
    repeat (3) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    chk("reset busy", 21'h0, {20'h0, busy_o});
    chk("reset readback", 21'h0, {13'h0, cmd_readback_o});
    t_lpcd();
    t_keyload();
    t_rx_abort_tx();
    t_transceive();
    t_nv();
    t_misc();
    summarize();
  end
endmodule : tb
`default_nettype wire

// File: verilog/rcs_arg_store.sv
/*
  Argument store: a small byte array filled in order, with registered read data.
  Assumes the caller clears the write index between commands.
*/
`timescale 1ns/100ps
`default_nettype none
module rcs_arg_store #(
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_n_i,
  // Write side.
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
  input  wire logic [7:0]               wr_data_i,
  // Read side.
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  output logic      [7:0]               rd_data_o
);
  logic [7:0] mem_ff [DEPTH];

  initial begin
    if (DEPTH < 7) $error("rcs_arg_store needs at least seven entries");
  end

  // Storage has no reset; entries not written by the current command can still be read.
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_idx_i] <= wr_data_i;
    end
  end

  // Registered read port.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_ff[rd_idx_i];
    end
  end
endmodule : rcs_arg_store
`default_nettype wire

// File: verilog/rcs_sequencer.sv
/*
  Command sequencer of a contactless reader front end. Takes a command code,
  gathers its arguments from the shared FIFO, then drives the radio, crypto,
  nonvolatile memory, register preset and random units through start and done
  strobes until the command ends or is replaced.
  Assumes the FIFO, units and memory are outside and answer with done pulses;
  the FIFO presents its head byte with a valid flag and an occupancy count.
*/
// Functional notes
// - Command write starts selected operation.
// - Wait until all argument bytes are present.
// - Command start never flushes the FIFO.
// - New command write aborts the running one.
// - Code 00h idles and cancels.
// - Code 01h starts card detection, no arguments.
// - Code 02h moves six key bytes to buffer.
// - Code 03h authenticates with code, block, serial.
// - Code 04h runs query, ack, req_rn.
// - Code 05h enables receiver, no arguments.
// - Code 06h transmits FIFO bytes in order.
// - Code 07h transmits then receives automatically.
// - Code 08h writes one byte at address.
// - Code 09h programs page of 64 bytes.
// - Code 0Ah copies memory bytes into FIFO.
// - Code 0Ch loads registers from sector two; code loads other sectors too, flagging error_o only when arg_q is 00h.
// - Code 0Dh loads receive and transmit presets.
// - Code 0Eh fetches stored key into buffer; code writes no key bytes, raises nv_rd_o while len_ff is nonzero and ends on unit_done_i.
// - Code 0Fh stores six key bytes into slot.
// - Code 1Ch fills FIFO with random bytes.
// - Memory read wraps 1FFFh to 0000h.
// - Transmit ends when FIFO empties.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_consts.svh"
module rcs_sequencer #(
  parameter int FIFO_CNT_W = 9
) (
  // Clock and reset.
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  // Command register port.
  input  wire logic                  cmd_wr_i,
  input  wire rcs_pkg::rcs_byte_t    cmd_code_i,
  output logic      [7:0]            cmd_readback_o,
  output logic                       busy_o,
  // FIFO side.
  input  wire logic                  fifo_valid_i,
  input  wire rcs_pkg::rcs_byte_t    fifo_data_i,
  input  wire logic [FIFO_CNT_W-1:0] fifo_count_i,
  input  wire logic                  fifo_full_i,
  output logic                       fifo_pop_o,
  output logic                       fifo_push_o,
  output logic      [7:0]            fifo_push_data_o,
  // Unit starts and completions.
  output logic                       lpcd_start_o,
  output logic                       auth_start_o,
  output logic                       ackreq_start_o,
  output logic                       tx_en_o,
  output logic                       rx_en_o,
  input  wire logic                  unit_done_i,
  input  wire logic                  tx_done_i,
  // Key buffer load.
  output logic                       key_wr_o,
  output logic      [2:0]            key_idx_o,
  output logic      [7:0]            key_data_o,
  // Nonvolatile memory.
  output logic                       nv_rd_o,
  output logic                       nv_wr_o,
  output logic      [12:0]           nv_addr_o,
  output logic      [7:0]            nv_wdata_o,
  input  wire logic                  nv_ack_i,
  input  wire logic [7:0]            nv_rdata_i,
  // Register preset writes and random source.
  output logic                       reg_wr_o,
  output logic      [7:0]            target_register_offset_o,
  output logic      [7:0]            reg_data_o,
  output logic                       preset_start_o,
  output logic      [7:0]            preset_rx_o,
  output logic      [7:0]            preset_tx_o,
  input  wire logic [7:0]            random_byte_i,
  output logic                       soft_reset_o,
  output logic                       error_o
);
  import rcs_pkg::*;

  initial begin
    if (FIFO_CNT_W < 7) $error("FIFO count must reach 64");
  end

  rcs_state_e  state_ff;
  logic [7:0]  cmd_ff;
  logic [2:0]  arg_cnt_ff;
  logic [2:0]  rd_idx_ff;
  logic [8:0]  len_ff;
  logic [12:0] addr_ff;
  logic [7:0]  arg_q;
  logic [7:0]  need;
  logic        pop_arg;

  // Argument byte counts per command.
  always_comb begin
    unique case (cmd_code_i)
      `RCS_CMD_LOADKEY:  need = `RCS_KEY_BYTES;
      `RCS_CMD_AUTH:     need = 8'h06;
      `RCS_CMD_WRE2:     need = 8'h03;
      `RCS_CMD_WRPAGE:   need = 8'h02;
      `RCS_CMD_RDE2:     need = 8'h03;
      `RCS_CMD_LOADREG:  need = 8'h04;
      `RCS_CMD_LOADPROT: need = 8'h02;
      `RCS_CMD_KEYFETCH: need = 8'h01;
      `RCS_CMD_KEYSTORE: need = 8'h07;
      default:           need = 8'h00;
    endcase
  end

  logic [7:0] need_ff;
  assign pop_arg = (state_ff == RCS_ARGS) && fifo_valid_i && (arg_cnt_ff != need_ff[2:0]);

  // A single byte write reads its data byte back once unpacking is done.
  logic [2:0] store_rd_idx;
  assign store_rd_idx = (rd_idx_ff == 3'h5 && cmd_ff == `RCS_CMD_WRE2) ? 3'h2 : rd_idx_ff;

  rcs_arg_store #(.DEPTH(8)) u_args (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_en_i    (pop_arg),
    .wr_idx_i   (arg_cnt_ff),
    .wr_data_i  (fifo_data_i),
    .rd_idx_i   (store_rd_idx),
    .rd_data_o  (arg_q)
  );

  // Command state: any write restarts, finished commands fall back to idle.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff   <= RCS_IDLE;
      cmd_ff     <= `RCS_CMD_IDLE;
      need_ff    <= 8'h00;
      arg_cnt_ff <= 3'h0;
      error_o    <= 1'b0;
    end else if (cmd_wr_i) begin
      cmd_ff     <= cmd_code_i;
      need_ff    <= need;
      arg_cnt_ff <= 3'h0;                                       // FIFO left untouched
      error_o    <= 1'b0;
      unique case (cmd_code_i)
        `RCS_CMD_IDLE:     state_ff <= RCS_IDLE;
        `RCS_CMD_LPCD:     state_ff <= RCS_LPCD;
        `RCS_CMD_ACKREQ:   state_ff <= RCS_ACKREQ;
        `RCS_CMD_RECEIVE:  state_ff <= RCS_RX;
        `RCS_CMD_TRANSMIT: state_ff <= RCS_TX;
        `RCS_CMD_TRANSCV:  state_ff <= RCS_TX;
        `RCS_CMD_RANDOM:   state_ff <= RCS_RANDOM;
        `RCS_CMD_SOFTRST:  state_ff <= RCS_RESET;
        default:           state_ff <= (need == 8'h00) ? RCS_IDLE : RCS_ARGS;
      endcase
    end else begin
      unique case (state_ff)
        RCS_IDLE: begin
          cmd_ff <= `RCS_CMD_IDLE;
        end
        RCS_ARGS: begin
          if (pop_arg) begin
            arg_cnt_ff <= arg_cnt_ff + 3'h1;
          end
          // Processing starts only once every argument is in hand.
          if (arg_cnt_ff == need_ff[2:0]) begin
            unique case (cmd_ff)
              `RCS_CMD_LOADKEY:  state_ff <= RCS_KEYLOAD;
              `RCS_CMD_AUTH:     state_ff <= RCS_AUTH;
              `RCS_CMD_WRE2,
              `RCS_CMD_WRPAGE,
              `RCS_CMD_KEYSTORE: state_ff <= RCS_NVWR;
              `RCS_CMD_RDE2:     state_ff <= RCS_NVRD;
              `RCS_CMD_LOADREG:  state_ff <= RCS_REGLOAD;
              `RCS_CMD_LOADPROT: state_ff <= RCS_PROT;
              default:           state_ff <= RCS_KEYNV;
            endcase
          end
        end
        RCS_TX: begin
          // Transmit ends once the FIFO drains; transceive then listens.
          if (tx_done_i && !fifo_valid_i) begin
            state_ff <= (cmd_ff == `RCS_CMD_TRANSCV) ? RCS_RX : RCS_IDLE;
          end
        end
        RCS_RANDOM: begin
          if (fifo_full_i) state_ff <= RCS_IDLE;
        end
        RCS_RESET: state_ff <= RCS_IDLE;
        RCS_KEYLOAD: begin
          if (rd_idx_ff == 3'h7) state_ff <= RCS_IDLE;
        end
        RCS_REGLOAD: begin
          if (arg_q == 8'h00 && rd_idx_ff == 3'h5 && addr_ff[12:11] != `RCS_SECTOR_SEL) begin
            error_o  <= 1'b1;
            state_ff <= RCS_IDLE;
          end else if (len_ff == 9'h000 && rd_idx_ff == 3'h5) begin
            state_ff <= RCS_IDLE;
          end
        end
        RCS_NVRD, RCS_NVWR: begin
          if (len_ff == 9'h000 && rd_idx_ff == 3'h5) state_ff <= RCS_IDLE;
        end
        RCS_AUTH: begin
          if (rd_idx_ff == 3'h5 && unit_done_i) state_ff <= RCS_IDLE;
        end
        default: begin
          if (unit_done_i) state_ff <= RCS_IDLE;
        end
      endcase
    end
  end

  // Argument unpacking: loads address and length from stored bytes.
  // The read port has one cycle of latency, so index 5 marks "unpacked".
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_idx_ff <= 3'h0;
      addr_ff   <= 13'h0000;
      len_ff    <= 9'h000;
    end else if (cmd_wr_i || state_ff == RCS_ARGS) begin
      rd_idx_ff <= 3'h0;
    end else if ((state_ff == RCS_KEYLOAD) ? (rd_idx_ff != 3'h7) : (rd_idx_ff != 3'h5)) begin
      // Key load walks all six stored bytes, so its index runs on to 7.
      rd_idx_ff <= rd_idx_ff + 3'h1;
      unique case (rd_idx_ff)
        3'h1: addr_ff[12:8] <= arg_q[4:0];                      // Address high byte.
        3'h2: addr_ff[7:0]  <= arg_q;                           // Address low byte.
        3'h3: len_ff        <= {1'b0, arg_q};                   // Length or data.
        3'h4: begin
          if (cmd_ff == `RCS_CMD_LOADREG) len_ff <= {1'b0, arg_q};
          else if (cmd_ff == `RCS_CMD_WRE2) len_ff <= 9'h001;
          else if (cmd_ff == `RCS_CMD_WRPAGE) len_ff <= {1'b0, `RCS_PAGE_BYTES};
          else if (cmd_ff == `RCS_CMD_KEYSTORE) len_ff <= 9'h006;
        end
        default: ;
      endcase
    end else if ((state_ff == RCS_NVRD || state_ff == RCS_REGLOAD || state_ff == RCS_NVWR)
                 && nv_ack_i && len_ff != 9'h000) begin
      len_ff  <= len_ff - 9'h001;
      addr_ff <= (addr_ff == `RCS_NV_LAST) ? 13'h0000 : addr_ff + 13'h0001;
    end
  end

  // Strobes to the units and memory.
  always_comb begin
    lpcd_start_o   = state_ff == RCS_LPCD;
    auth_start_o   = state_ff == RCS_AUTH && rd_idx_ff == 3'h5;
    ackreq_start_o = state_ff == RCS_ACKREQ;
    tx_en_o        = state_ff == RCS_TX;
    rx_en_o        = state_ff == RCS_RX;
    soft_reset_o   = state_ff == RCS_RESET;
    preset_start_o = state_ff == RCS_PROT;
    busy_o         = state_ff != RCS_IDLE;
    cmd_readback_o = cmd_ff;
    nv_rd_o        = (state_ff == RCS_NVRD || state_ff == RCS_REGLOAD || state_ff == RCS_KEYNV)
                     && rd_idx_ff == 3'h5 && len_ff != 9'h000;
    nv_wr_o        = state_ff == RCS_NVWR && rd_idx_ff == 3'h5 && len_ff != 9'h000
                     && (fifo_valid_i || cmd_ff == `RCS_CMD_WRE2);
    nv_addr_o      = addr_ff;
    nv_wdata_o     = (cmd_ff == `RCS_CMD_WRE2) ? arg_q : fifo_data_i;
    fifo_pop_o     = pop_arg || (tx_en_o && fifo_valid_i) || (nv_wr_o && nv_ack_i
                     && cmd_ff != `RCS_CMD_WRE2);
  end

  // Data outputs registered: FIFO pushes, key and register writes.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fifo_push_o      <= 1'b0;
      fifo_push_data_o <= 8'h00;
      key_wr_o         <= 1'b0;
      key_idx_o        <= 3'h0;
      key_data_o       <= 8'h00;
      reg_wr_o         <= 1'b0;
      reg_data_o       <= 8'h00;
      target_register_offset_o <= 8'h00;
      preset_rx_o      <= 8'h00;
      preset_tx_o      <= 8'h00;
    end else begin
      // Random pushes skip a cycle so the full flag is seen before the next one.
      fifo_push_o <= (state_ff == RCS_RANDOM && !fifo_full_i && !cmd_wr_i && !fifo_push_o)
                     || (state_ff == RCS_NVRD && nv_ack_i);
      fifo_push_data_o <= (state_ff == RCS_RANDOM) ? random_byte_i : nv_rdata_i;
      key_wr_o   <= state_ff == RCS_KEYLOAD && rd_idx_ff != 3'h0 && rd_idx_ff != 3'h7;
      key_idx_o  <= rd_idx_ff - 3'h1;
      key_data_o <= arg_q;
      reg_wr_o   <= state_ff == RCS_REGLOAD && nv_ack_i;
      reg_data_o <= nv_rdata_i;
      if (state_ff == RCS_REGLOAD && rd_idx_ff == 3'h3) target_register_offset_o <= arg_q;
      else if (reg_wr_o) target_register_offset_o <= target_register_offset_o + 8'h01;
      if (state_ff == RCS_PROT && rd_idx_ff == 3'h1) preset_rx_o <= arg_q;
      if (state_ff == RCS_PROT && rd_idx_ff == 3'h2) preset_tx_o <= arg_q;
    end
  end

  // Checks next to the logic they guard.
  idle_cancel_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_wr_i && cmd_code_i == `RCS_CMD_IDLE |=> !busy_o) else $error("idle did not cancel");
  abort_new_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_wr_i |=> cmd_readback_o == $past(cmd_code_i)) else $error("command not taken");
  args_wait_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    state_ff == RCS_ARGS && arg_cnt_ff != need_ff[2:0] && !cmd_wr_i |=> state_ff == RCS_ARGS)
    else $error("started without arguments");
  no_flush_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_wr_i |-> !fifo_pop_o || state_ff == RCS_ARGS || state_ff == RCS_TX || state_ff == RCS_NVWR)
    else $error("flush at start");
  tx_end_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    tx_en_o && tx_done_i && !fifo_valid_i && !cmd_wr_i && cmd_ff == `RCS_CMD_TRANSMIT |=> !busy_o)
    else $error("transmit did not end");
  transceive_rx_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    tx_en_o && tx_done_i && !fifo_valid_i && !cmd_wr_i && cmd_ff == `RCS_CMD_TRANSCV |=> rx_en_o)
    else $error("receiver not enabled");
  nv_wrap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    nv_rd_o && nv_ack_i && addr_ff == `RCS_NV_LAST && !cmd_wr_i |=> addr_ff == 13'h0000)
    else $error("address did not wrap");
  random_fill_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    state_ff == RCS_RANDOM && !fifo_full_i && !cmd_wr_i && !fifo_push_o |=> fifo_push_o)
    else $error("random byte missing");
  reset_pulse_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_wr_i && cmd_code_i == `RCS_CMD_SOFTRST |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
endmodule : rcs_sequencer
`default_nettype wire
